// File: logic/tec16_top.sv
// Top of the 16-bit timer/event counter with AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.

module tec16_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Timer pins
   input wire logic timer_input_a,
   input wire logic timer_input_b,
   output logic timer_output_line,
   // Match events
   output logic match_irq_a,
   output logic match_irq_b
);

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] cc_a;
      logic [15:0] cc_b;
      tec16_pkg::tec16_run_e run_mode;
      logic ovf;
      logic cap_a_en;
      logic src_a;
      logic cap_b_en;
      logic tog_a;
      logic tog_b;
      logic drive_en;
      logic [1:0] edge_a;
      logic [1:0] edge_b;
      logic [1:0] clk_sel;
      logic out_ff;
      logic out_line;
      logic irq_a;
      logic irq_b;
      logic tick_pend;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
      logic resp;
   } tec16_state_s;

   tec16_state_s st_ff;
   tec16_state_s nxt_st;

   logic a_level;
   logic a_rise;
   logic a_fall;
   logic b_level;
   logic b_rise;
   logic b_fall;
   logic div_tick;
   logic acc_ok;
   logic rd_go;
   logic running;
   logic cnt_read;
   logic raw_tick;
   logic tick_go;
   logic edge_a_ok;
   logic edge_b_ok;
   logic clr_edge;
   logic hit_a;
   logic hit_b;
   logic match_a;
   logic match_b;
   logic clr_match;
   logic ovf_evt;
   logic cap_a;
   logic cap_b;
   logic out_wr;
   logic [1:0] a_opp_code;

   // Filtered inputs and count clock source
   tec16_noise_filter u_filt_a (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(timer_input_a),
      .level(a_level),
      .rise(a_rise),
      .fall(a_fall)
   );

   tec16_noise_filter u_filt_b (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(timer_input_b),
      .level(b_level),
      .rise(b_rise),
      .fall(b_fall)
   );

   tec16_prescaler u_presc (
      .hclk(hclk),
      .hresetn(hresetn),
      .sel(st_ff.clk_sel),
      .tick(div_tick)
   );

   // Bus access qualification
   assign acc_ok = hsel & htrans[1] & hready &
                   (hsize == tec16_pkg::HSIZE_WORD);
   assign rd_go = acc_ok & ~hwrite;
   assign running = st_ff.run_mode != tec16_pkg::TEC16_RUN_STOP;
   assign cnt_read = rd_go & (haddr[7:0] == tec16_pkg::OFS_COUNT) & running;

   // Count tick; event mode counts filtered input A edges
   assign raw_tick = (st_ff.clk_sel == tec16_pkg::CLK_SEL_EXT) ?
                     edge_a_ok : div_tick;
   // A read defers the tick by one cycle instead of losing it
   assign tick_go = running & ~cnt_read & (raw_tick | st_ff.tick_pend);

   // Valid edges; the prohibited code decodes to no edge
   assign edge_a_ok = tec16_pkg::valid_edge(st_ff.edge_a, a_rise, a_fall);
   assign edge_b_ok = tec16_pkg::valid_edge(st_ff.edge_b, b_rise, b_fall);
   assign clr_edge = (st_ff.run_mode == tec16_pkg::TEC16_RUN_EDGE_CLR) &
                     edge_a_ok;

   // Compare against both registers at the count step
   assign hit_a = tick_go & (st_ff.count == st_ff.cc_a);
   assign hit_b = tick_go & (st_ff.count == st_ff.cc_b);
   assign match_a = hit_a & ~st_ff.cap_a_en;
   assign match_b = hit_b & ~st_ff.cap_b_en;
   // Interval length held in register A gives period A+1
   assign clr_match = hit_a &
                      (st_ff.run_mode == tec16_pkg::TEC16_RUN_MATCH_CLR);
   assign ovf_evt = tick_go & ~clr_edge &
                    (st_ff.count == tec16_pkg::COUNT_MAX);

   // Input A opposite phase for register A: 01 falls, 00 rises, 11 none
   always_comb begin
      case (st_ff.edge_a)
         tec16_pkg::EDGE_RISE: a_opp_code = tec16_pkg::EDGE_FALL;
         tec16_pkg::EDGE_FALL: a_opp_code = tec16_pkg::EDGE_RISE;
         default: a_opp_code = 2'b10;
      endcase
   end

   // Capture triggers, pulse width measured by filtered edges
   assign cap_a = st_ff.cap_a_en & (st_ff.src_a ?
                  tec16_pkg::valid_edge(a_opp_code, a_rise, a_fall) :
                  edge_b_ok);
   assign cap_b = st_ff.cap_b_en & edge_a_ok;

   assign out_wr = st_ff.wr_pend & (st_ff.wr_addr == tec16_pkg::OFS_OUTCTL);

   // Next state of counter, registers, output and bus
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ready = 1'b1;
      nxt_st.resp = 1'b0;
      nxt_st.irq_a = match_a;
      nxt_st.irq_b = match_b;

      // Counter with its clear cases
      if (!running) begin
         nxt_st.count = tec16_pkg::RST_REG16;
      end else if (clr_edge) begin
         nxt_st.count = tec16_pkg::RST_REG16;
      end else if (tick_go) begin
         if (clr_match) begin
            nxt_st.count = tec16_pkg::RST_REG16;
         end else begin
            nxt_st.count = 16'(st_ff.count + 16'h0001);
         end
      end
      nxt_st.tick_pend = running & cnt_read & (raw_tick | st_ff.tick_pend);

      // Register writes in the data phase
      if (st_ff.wr_pend) begin
         case (st_ff.wr_addr)
            tec16_pkg::OFS_CCA: nxt_st.cc_a = hwdata[15:0];
            tec16_pkg::OFS_CCB: nxt_st.cc_b = hwdata[15:0];
            tec16_pkg::OFS_MODE: begin
               nxt_st.run_mode = tec16_pkg::tec16_run_e'(
                  hwdata[tec16_pkg::MODE_RUN_LSB +: 2]);
               nxt_st.ovf = hwdata[tec16_pkg::MODE_OVF_BIT];
            end
            tec16_pkg::OFS_CCCTL: begin
               nxt_st.cap_a_en = hwdata[tec16_pkg::CC_A_CAP_BIT];
               nxt_st.src_a = hwdata[tec16_pkg::CC_A_SRC_BIT];
               nxt_st.cap_b_en = hwdata[tec16_pkg::CC_B_CAP_BIT];
            end
            tec16_pkg::OFS_OUTCTL: begin
               nxt_st.drive_en = hwdata[tec16_pkg::OUT_EN_BIT];
               nxt_st.tog_a = hwdata[tec16_pkg::OUT_TOGA_BIT];
               nxt_st.tog_b = hwdata[tec16_pkg::OUT_TOGB_BIT];
            end
            tec16_pkg::OFS_PRESC: begin
               nxt_st.clk_sel = hwdata[tec16_pkg::PRE_SEL_LSB +: 2];
               nxt_st.edge_a = hwdata[tec16_pkg::PRE_EA_LSB +: 2];
               nxt_st.edge_b = hwdata[tec16_pkg::PRE_EB_LSB +: 2];
            end
            default: nxt_st.count = nxt_st.count;
         endcase
      end
      // Overflow set wins over a software clear
      nxt_st.ovf = nxt_st.ovf | ovf_evt;

      // Captures take the current count and win over a write
      if (cap_a) begin
         nxt_st.cc_a = st_ff.count;
      end
      if (cap_b) begin
         nxt_st.cc_b = st_ff.count;
      end

      // Output flip-flop: match toggles give square wave and PPG
      if ((match_a & st_ff.tog_a) ^ (match_b & st_ff.tog_b)) begin
         nxt_st.out_ff = ~st_ff.out_ff;
      end
      // Software force set or reset; both together is ignored
      if (out_wr) begin
         if (hwdata[tec16_pkg::OUT_FSET_BIT] &
             ~hwdata[tec16_pkg::OUT_FRST_BIT]) begin
            nxt_st.out_ff = 1'b1;
         end else if (hwdata[tec16_pkg::OUT_FRST_BIT] &
                      ~hwdata[tec16_pkg::OUT_FSET_BIT]) begin
            nxt_st.out_ff = 1'b0;
         end
      end
      nxt_st.out_line = nxt_st.drive_en & nxt_st.out_ff;

      // Address phase capture and read data snapshot
      nxt_st.wr_pend = acc_ok & hwrite;
      nxt_st.wr_addr = haddr[7:0];
      nxt_st.rdata = tec16_pkg::RDATA_ZERO;
      if (rd_go) begin
         case (haddr[7:0])
            tec16_pkg::OFS_COUNT: nxt_st.rdata = {16'h0000, st_ff.count};
            tec16_pkg::OFS_CCA: nxt_st.rdata = {16'h0000, st_ff.cc_a};
            tec16_pkg::OFS_CCB: nxt_st.rdata = {16'h0000, st_ff.cc_b};
            tec16_pkg::OFS_MODE: nxt_st.rdata = {28'h0000000,
               st_ff.run_mode, 1'b0, st_ff.ovf};
            tec16_pkg::OFS_CCCTL: nxt_st.rdata = {29'h00000000,
               st_ff.cap_b_en, st_ff.src_a, st_ff.cap_a_en};
            tec16_pkg::OFS_OUTCTL: nxt_st.rdata = {27'h0000000,
               st_ff.tog_b, 2'b00, st_ff.tog_a, st_ff.drive_en};
            tec16_pkg::OFS_PRESC: nxt_st.rdata = {24'h000000,
               st_ff.edge_b, st_ff.edge_a, 2'b00, st_ff.clk_sel};
            default: nxt_st.rdata = tec16_pkg::RDATA_ZERO;
         endcase
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   assign hreadyout = st_ff.ready;
   assign hresp = st_ff.resp;
   assign hrdata = st_ff.rdata;
   assign timer_output_line = st_ff.out_line;
   assign match_irq_a = st_ff.irq_a;
   assign match_irq_b = st_ff.irq_b;

   // Checks on counter, capture and output behaviour
   default clocking tec16_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   count_stop_a: assert property (
      st_ff.run_mode == tec16_pkg::TEC16_RUN_STOP |=>
      st_ff.count == 16'h0000)
      else $error("counter not held at zero while stopped");

   count_step_a: assert property (
      tick_go && !clr_match && !clr_edge |=>
      st_ff.count == 16'($past(st_ff.count) + 16'h0001))
      else $error("counter did not advance by one");

   read_freeze_a: assert property (
      cnt_read && !clr_edge |=>
      st_ff.count == $past(st_ff.count) && st_ff.rdata[15:0] == st_ff.count)
      else $error("counter moved during a read");

   match_clear_a: assert property (
      clr_match && !clr_edge |=> st_ff.count == 16'h0000 &&
      match_irq_a == !$past(st_ff.cap_a_en))
      else $error("match clear did not restart the counter");

   match_irq_a_a: assert property (
      match_irq_a |-> $past(st_ff.count) == $past(st_ff.cc_a) &&
      !$past(st_ff.cap_a_en))
      else $error("match A without equal count");

   match_irq_b_a: assert property (
      hit_b && !st_ff.cap_b_en |=> match_irq_b)
      else $error("match B not raised");

   capture_a_a: assert property (
      cap_a |=> st_ff.cc_a == $past(st_ff.count))
      else $error("capture A did not copy the counter");

   capture_b_a: assert property (
      cap_b |=> st_ff.cc_b == $past(st_ff.count))
      else $error("capture B did not copy the counter");

   output_low_a: assert property (
      !st_ff.drive_en |-> !timer_output_line)
      else $error("timer output driven while disabled");

   toggle_out_a: assert property (
      match_a && st_ff.tog_a && !(match_b && st_ff.tog_b) && !out_wr |=>
      st_ff.out_ff != $past(st_ff.out_ff))
      else $error("output did not toggle on match A");

   ovf_set_a: assert property (
      ovf_evt |=> st_ff.ovf)
      else $error("overflow flag not set");

   match_seen_c: cover property (match_a ##1 match_irq_a);
   capture_seen_c: cover property (cap_a);
   wrap_seen_c: cover property (clr_match ##[1:300] clr_match);
   toggle_seen_c: cover property (out_wr ##1 timer_output_line);

endmodule : tec16_top

// File: logic/tec16_pkg.sv
// Shared constants for the 16-bit timer/event counter
package tec16_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_CCA = 8'h04;
   localparam logic [7:0] OFS_CCB = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_CCCTL = 8'h10;
   localparam logic [7:0] OFS_OUTCTL = 8'h14;
   localparam logic [7:0] OFS_PRESC = 8'h18;

   // Values after reset and the counter's top value
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // Field positions: timer_mode_control
   localparam int MODE_OVF_BIT = 0;
   localparam int MODE_RUN_LSB = 2;
   // Field positions: capcmp_control
   localparam int CC_A_CAP_BIT = 0;
   localparam int CC_A_SRC_BIT = 1;
   localparam int CC_B_CAP_BIT = 2;
   // Field positions: output_control
   localparam int OUT_EN_BIT = 0;
   localparam int OUT_TOGA_BIT = 1;
   localparam int OUT_FRST_BIT = 2;
   localparam int OUT_FSET_BIT = 3;
   localparam int OUT_TOGB_BIT = 4;
   // Field positions: prescaler_edge_config
   localparam int PRE_SEL_LSB = 0;
   localparam int PRE_EA_LSB = 4;
   localparam int PRE_EB_LSB = 6;

   // Run modes
   typedef enum logic [1:0] {
      TEC16_RUN_STOP = 2'b00,
      TEC16_RUN_FREE = 2'b01,
      TEC16_RUN_EDGE_CLR = 2'b10,
      TEC16_RUN_MATCH_CLR = 2'b11
   } tec16_run_e;

   // Edge select codes; code 2'b10 is prohibited and decodes to no edge
   localparam logic [1:0] EDGE_FALL = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_BOTH = 2'b11;

   // Count clock select: three hclk divisions and the external event input
   localparam logic [1:0] CLK_SEL_EXT = 2'b11;
   localparam logic [5:0] DIV_MASK_4 = 6'h03;
   localparam logic [5:0] DIV_MASK_16 = 6'h0F;
   localparam logic [5:0] DIV_MASK_64 = 6'h3F;

   // Noise eliminator: cycles a new level must stand before it is taken
   localparam logic [2:0] NOISE_STABLE = 3'h2;

   // AHB-Lite encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Valid edge decode shared by capture, clear and event logic
   function automatic logic valid_edge(input logic [1:0] code,
                                       input logic rise,
                                       input logic fall);
      case (code)
         EDGE_FALL: valid_edge = fall;
         EDGE_RISE: valid_edge = rise;
         EDGE_BOTH: valid_edge = rise | fall;
         default: valid_edge = 1'b0;
      endcase
   endfunction : valid_edge

endpackage : tec16_pkg

// File: logic/tec16_noise_filter.sv
// Synchroniser and noise eliminator for one timer input pin
module tec16_noise_filter (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Raw pin
   input wire logic pin,
   // Filtered level and edge pulses
   output logic level,
   output logic rise,
   output logic fall
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [2:0] cnt;
      logic level;
      logic rise;
      logic fall;
   } tec16_nf_s;

   tec16_nf_s st_ff;
   tec16_nf_s nxt_st;

   // Level is accepted only after it stands for the stable count
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sync1 = pin;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.rise = 1'b0;
      nxt_st.fall = 1'b0;
      if (st_ff.sync2 != st_ff.level) begin
         if (3'(st_ff.cnt + 3'h1) >= tec16_pkg::NOISE_STABLE) begin
            nxt_st.level = st_ff.sync2;
            nxt_st.rise = st_ff.sync2;
            nxt_st.fall = ~st_ff.sync2;
            nxt_st.cnt = 3'h0;
         end else begin
            nxt_st.cnt = 3'(st_ff.cnt + 3'h1);
         end
      end else begin
         nxt_st.cnt = 3'h0;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.level;
   assign rise = st_ff.rise;
   assign fall = st_ff.fall;

endmodule : tec16_noise_filter

// File: logic/tec16_prescaler.sv
// Count clock divider producing a one-cycle tick from hclk
module tec16_prescaler (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Division select
   input wire logic [1:0] sel,
   // Count tick
   output logic tick
);

   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
   } tec16_ps_s;

   tec16_ps_s st_ff;
   tec16_ps_s nxt_st;
   logic [5:0] mask;

   // Division mask from the select code
   always_comb begin
      case (sel)
         2'b00: mask = tec16_pkg::DIV_MASK_4;
         2'b01: mask = tec16_pkg::DIV_MASK_16;
         default: mask = tec16_pkg::DIV_MASK_64;
      endcase
   end

   // Free-running divider
   always_comb begin
      nxt_st = st_ff;
      nxt_st.cnt = 6'(st_ff.cnt + 6'h01);
      nxt_st.tick = (st_ff.cnt & mask) == mask;
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;

endmodule : tec16_prescaler

// File: sim/tec16_pins_model.sv
// Behavioural model of the pulse sources and the load on the timer pins
module tec16_pins_model (
   // Clock
   input wire logic hclk,
   // Timer pins
   output logic timer_input_a,
   output logic timer_input_b,
   input wire logic timer_output_line
);
   timeunit 1ns;
   timeprecision 100ps;

   int cyc = 0;
   int last_toggle = 0;
   int toggle_gap = 0;
   logic line_q = 1'b0;

   // Both sources rest low between pulses
   initial begin
      timer_input_a = 1'b0;
      timer_input_b = 1'b0;
   end

   // Measure the spacing of the last two changes on the output line
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      line_q <= timer_output_line;
      if (timer_output_line !== line_q) begin
         toggle_gap <= cyc - last_toggle;
         last_toggle <= cyc;
      end
   end

   // Set one pin to the given level just after a clock edge
   task automatic drive(input logic use_b, input logic lvl);
      @(posedge hclk);
      if (use_b) begin
         timer_input_b <= lvl;
      end else begin
         timer_input_a <= lvl;
      end
   endtask : drive

   // High pulse of a given width in clocks, then a low gap
   task automatic pulse(input logic use_b, input int width, input int gap);
      drive(use_b, 1'b1);
      repeat (width - 1) @(posedge hclk);
      drive(use_b, 1'b0);
      repeat (gap) @(posedge hclk);
   endtask : pulse
endmodule : tec16_pins_model

// File: sim/timer_event_counter_16_test.sv
// Self-checking bench for the 16-bit timer/event counter
module timer_event_counter_16_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, v, w;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic tin_a, tin_b, tout, irq_a, irq_b, cap;
   logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int ma_cyc = 0;
   int ma_gap = 0;
   int mb_cyc = 0;

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   tec16_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .timer_input_a(tin_a),
      .timer_input_b(tin_b), .timer_output_line(tout),
      .match_irq_a(irq_a), .match_irq_b(irq_b));

   tec16_pins_model i_pins (.hclk(hclk), .timer_input_a(tin_a),
      .timer_input_b(tin_b), .timer_output_line(tout));

   // 200 MHz clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // Record when the match pulses arrive
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (irq_a === 1'b1) begin
         ma_gap <= cyc - ma_cyc;
         ma_cyc <= cyc;
      end
      if (irq_b === 1'b1) begin
         mb_cyc <= cyc;
      end
   end

   // Print the verdict and stop
   task automatic complete_run();
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // One AHB-Lite single word transfer, waiting on ready in each phase
   task automatic bus(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, ofs};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= tec16_pkg::HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0, "okay response");
   endtask : bus

   // Register write
   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, ofs, d, dummy);
   endtask : wr

   // Register read with expected value
   task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp,
                         input string msg);
      logic [31:0] got;
      bus(1'b0, ofs, 32'h0000_0000, got);
      chk(got, exp, msg);
   endtask : rd_chk

   // Cut a hang short
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      complete_run();
   end

   // Test sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = tec16_pkg::HSIZE_WORD;
      hwdata = 32'h0000_0000;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, read-only counter, unmapped place, plain readback
      rd_chk(tec16_pkg::OFS_COUNT, 32'h0, "count reset");
      rd_chk(tec16_pkg::OFS_MODE, 32'h0, "mode reset");
      wr(tec16_pkg::OFS_COUNT, 32'h0000_1234);
      rd_chk(tec16_pkg::OFS_COUNT, 32'h0, "count write");
      wr(8'h1C, 32'hFFFF_FFFF);
      rd_chk(8'h1C, 32'h0, "unmapped read");
      wr(tec16_pkg::OFS_CCB, 32'h0000_A5C3);
      rd_chk(tec16_pkg::OFS_CCB, 32'h0000_A5C3, "reg b readback");
      // Free run from hclk/4: 43 cycles between reads give 10 or 11 ticks
      wr(tec16_pkg::OFS_MODE, 32'h0000_0004);
      bus(1'b0, tec16_pkg::OFS_COUNT, 32'h0, v);
      repeat (40) @(posedge hclk);
      bus(1'b0, tec16_pkg::OFS_COUNT, 32'h0, w);
      chk(32'(((w - v) == 10) || ((w - v) == 11)), 32'h1, "rate");
      // Slower divisions over 259 cycles: 16 or 17, then 4 or 5 ticks
      for (int d = 1; d < 3; d++) begin
         wr(tec16_pkg::OFS_PRESC, 32'(d));
         bus(1'b0, tec16_pkg::OFS_COUNT, 32'h0, v);
         repeat (256) @(posedge hclk);
         bus(1'b0, tec16_pkg::OFS_COUNT, 32'h0, w);
         v = w - v;
         chk(32'((d == 1) ? (v == 16 || v == 17) : (v == 4 || v == 5)),
             32'h1, "divided rate");
      end
      wr(tec16_pkg::OFS_PRESC, 32'h0);
      wr(tec16_pkg::OFS_MODE, 32'h0);
      rd_chk(tec16_pkg::OFS_COUNT, 32'h0, "stop clears");
      // Match clear at 5: period 6 ticks of 4 clocks, output toggles on A
      wr(tec16_pkg::OFS_CCA, 32'h0000_0005);
      wr(tec16_pkg::OFS_CCB, 32'h0000_0003);
      wr(tec16_pkg::OFS_OUTCTL, 32'h0000_0003);
      wr(tec16_pkg::OFS_MODE, 32'h0000_000C);
      repeat (200) @(posedge hclk);
      chk(ma_gap, 24, "interval a");
      chk((ma_cyc - mb_cyc + 24) % 24, 8, "match b lead");
      chk(i_pins.toggle_gap, 24, "square wave");
      // Toggle on both matches: A to B spans 4 ticks of the 6-tick period
      wr(tec16_pkg::OFS_OUTCTL, 32'h0000_0013);
      @(posedge hclk iff irq_a === 1'b1);
      repeat (20) @(posedge hclk);
      chk(i_pins.toggle_gap, 16, "ppg width");
      bus(1'b0, tec16_pkg::OFS_COUNT, 32'h0, v);
      chk(32'(v <= 5), 32'h1, "match clear bound");
      // Forced output levels and drive enable
      wr(tec16_pkg::OFS_MODE, 32'h0);
      wr(tec16_pkg::OFS_OUTCTL, 32'h0000_0009);
      repeat (3) @(posedge hclk);
      chk(tout, 1'b1, "force set");
      wr(tec16_pkg::OFS_OUTCTL, 32'h0000_0005);
      repeat (3) @(posedge hclk);
      chk(tout, 1'b0, "force reset");
      wr(tec16_pkg::OFS_OUTCTL, 32'h0000_0008);
      repeat (3) @(posedge hclk);
      chk(tout, 1'b0, "drive off low");
      wr(tec16_pkg::OFS_OUTCTL, 32'h0000_0001);
      repeat (3) @(posedge hclk);
      chk(tout, 1'b1, "drive on");
      rd_chk(tec16_pkg::OFS_OUTCTL, 32'h0000_0001, "force bits");
      wr(tec16_pkg::OFS_OUTCTL, 32'h0);
      // Capture of register A for each edge code of inputs B (s=0), A (s=1)
      wr(tec16_pkg::OFS_MODE, 32'h0000_0004);
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 3; k++) begin
            // Codes come from a table without the prohibited one
            wr(tec16_pkg::OFS_PRESC, (s == 1) ? {26'h0, codes[k], 4'h0}
                                              : {24'h0, codes[k], 6'h00});
            wr(tec16_pkg::OFS_CCCTL, {30'h0, s[0], 1'b1});
            for (int ph = 0; ph < 2; ph++) begin
               wr(tec16_pkg::OFS_CCA, 32'h0);
               i_pins.drive(s == 0, ph == 0);
               repeat (12) @(posedge hclk);
               bus(1'b0, tec16_pkg::OFS_CCA, 32'h0, v);
               bus(1'b0, tec16_pkg::OFS_COUNT, 32'h0, w);
               if (s == 1) begin
                  cap = (ph == 0) ? (codes[k] == 2'b00) : (codes[k] == 2'b01);
               end else begin
                  cap = (ph == 0) ? (codes[k] != 2'b00) : (codes[k] != 2'b01);
               end
               chk(32'(cap ? (v != 0 && (w - v) < 16) : (v == 0)), 32'h1,
                   "capture a");
            end
         end
      end
      // Width of a 40-clock pulse on A: B on rise, A on fall, 10 ticks apart
      wr(tec16_pkg::OFS_PRESC, 32'h0000_0010);
      wr(tec16_pkg::OFS_CCCTL, 32'h0000_0007);
      i_pins.pulse(1'b0, 40, 12);
      bus(1'b0, tec16_pkg::OFS_CCA, 32'h0, v);
      bus(1'b0, tec16_pkg::OFS_CCB, 32'h0, w);
      chk(v - w, 32'h0000_000A, "pulse width");
      // Clear and restart on a rising edge of input A
      wr(tec16_pkg::OFS_CCCTL, 32'h0);
      wr(tec16_pkg::OFS_MODE, 32'h0000_0008);
      repeat (100) @(posedge hclk);
      i_pins.pulse(1'b0, 4, 10);
      bus(1'b0, tec16_pkg::OFS_COUNT, 32'h0, w);
      chk(32'(w < 8), 32'h1, "edge clear");
      // Event counting on input A, then a glitch that must be dropped
      wr(tec16_pkg::OFS_MODE, 32'h0);
      wr(tec16_pkg::OFS_PRESC, 32'h0000_0013);
      wr(tec16_pkg::OFS_MODE, 32'h0000_0004);
      repeat (5) i_pins.pulse(1'b0, 16, 16);
      rd_chk(tec16_pkg::OFS_COUNT, 32'h0000_0005, "events");
      i_pins.pulse(1'b0, 1, 16);
      rd_chk(tec16_pkg::OFS_COUNT, 32'h0000_0005, "glitch");
      complete_run();
   end
endmodule : timer_event_counter_16_test
